// ### hw/mass_pkg.sv
package mass_pkg;

  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned OFFSET_TO_BIAS_DELAY_MS = 2;
  localparam int unsigned OFFSET_TO_BIAS_MIN_MS = 1;
  localparam int unsigned OFFSET_TO_BIAS_CYCLES = OFFSET_TO_BIAS_DELAY_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned PARK_TIMEOUT_CYCLES = 1000;
  localparam int unsigned DELAY_W = 24;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DELAY = 8'h08;

  // Control bits
  localparam int unsigned CTRL_POWER_ON = 0;
  localparam int unsigned CTRL_PARK_DONE = 1;
  localparam int unsigned CTRL_BIAS_DONE = 2;

  // Status bits
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_STATE_W = 4;
  localparam int unsigned STAT_PGOOD = 4;
  localparam int unsigned STAT_EMERG = 5;

  typedef enum logic [3:0] {
    MASS_OFF,
    MASS_WAIT_HOLD,
    MASS_LOGIC_UP,
    MASS_OFFSET_UP,
    MASS_BIAS_DELAY,
    MASS_BIAS_CMD,
    MASS_RUN,
    MASS_PARK,
    MASS_DOWN_OFFSET,
    MASS_DISCHARGE,
    MASS_EMERG
  } mass_state_type;

  typedef struct packed {
    logic logic_supply_en;
    logic mirror_offset_supply_en;
    logic mirror_bias_supply_en;
    logic mirror_release_supply_en;
    logic power_down_n;
    logic mirror_output_disable_n;
    logic logic_inputs_en;
    logic global_bias_cmd;
    logic park_req;
  } mass_drive_type;

  typedef struct packed {
    logic logic_supply_good;
    logic offset_power_good;
    logic supplies_discharged;
    logic output_enable_hold_n;
    logic power_lost;
  } mass_sense_type;

endpackage

// ### hw/mass_delay.sv
`timescale 1ns/10ps
module mass_delay
#(
  parameter int unsigned WIDTH = 24
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [WIDTH-1:0] cycles,
  output logic done
);
  logic [WIDTH-1:0] count_q;
  logic busy_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= '0;
      busy_q <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      count_q <= cycles;
      busy_q <= 1'b1;
      done <= 1'b0;
    end
    else if (busy_q)
    begin
      if (count_q <= 1)
      begin
        busy_q <= 1'b0;
        done <= 1'b1;
      end
      else
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ### hw/mass_apb.sv
`timescale 1ns/10ps
module mass_apb
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] status,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] ctrl_q,
  output logic [23:0] delay_q
);
  import mass_pkg::*;

  logic access;
  logic commit;

  // Read data and error are set up in the setup cycle; a write lands only at the ready edge
  assign access = psel && !penable;
  assign commit = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= '0;
      delay_q <= DELAY_W'(OFFSET_TO_BIAS_CYCLES);
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access;
      pslverr <= 1'b0;
      if (commit)
      begin
        case (paddr)
          REG_CTRL:
            ctrl_q <= pwdata;
          REG_DELAY:
            delay_q <= pwdata[23:0];
          default:
          begin
          end
        endcase
      end
      if (access)
      begin
        case (paddr)
          REG_CTRL:
            prdata <= ctrl_q;
          REG_STATUS:
            prdata <= status;
          REG_DELAY:
            prdata <= {8'h00, delay_q};
          default:
          begin
            prdata <= '0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ### hw/mass_top.sv
`timescale 1ns/10ps
module mass_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mass_pkg::mass_sense_type sense,
  output mass_pkg::mass_drive_type drive
);
  import mass_pkg::*;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [23:0] delay_q;
  logic [31:0] status;
  mass_state_type state_q;
  logic emerg_q;

  assign status = {26'h0, emerg_q, sense.offset_power_good, state_q};

  mass_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .status(status),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl_q(ctrl_q),
    .delay_q(delay_q)
  );

  // ---------------------------------------------------------------
  // Offset-to-bias delay
  // ---------------------------------------------------------------
  logic delay_start;
  logic delay_done;

  assign delay_start = (state_q == MASS_OFFSET_UP) && sense.offset_power_good;

  mass_delay #(.WIDTH(DELAY_W)) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .start(delay_start),
    .cycles(delay_q),
    .done(delay_done)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= MASS_OFF;
      emerg_q <= 1'b0;
    end
    else if (sense.power_lost && state_q != MASS_OFF && state_q != MASS_EMERG
             && state_q != MASS_DISCHARGE)
    begin
      state_q <= MASS_EMERG;
      emerg_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        MASS_OFF:
          // No new power-up while input power is failing
          if (ctrl_q[CTRL_POWER_ON] && !sense.power_lost)
          begin
            emerg_q <= 1'b0;
            state_q <= MASS_WAIT_HOLD;
          end
        MASS_WAIT_HOLD:
          if (sense.output_enable_hold_n)
            state_q <= MASS_LOGIC_UP;
        MASS_LOGIC_UP:
          if (sense.logic_supply_good)
            state_q <= MASS_OFFSET_UP;
        MASS_OFFSET_UP:
          if (sense.offset_power_good)
            state_q <= MASS_BIAS_DELAY;
        MASS_BIAS_DELAY:
          if (delay_done)
            state_q <= MASS_BIAS_CMD;
        MASS_BIAS_CMD:
          if (ctrl_q[CTRL_BIAS_DONE])
            state_q <= MASS_RUN;
        MASS_RUN:
          if (!ctrl_q[CTRL_POWER_ON])
            state_q <= MASS_PARK;
        MASS_PARK:
          if (ctrl_q[CTRL_PARK_DONE])
            state_q <= MASS_DOWN_OFFSET;
        MASS_DOWN_OFFSET:
          if (!sense.offset_power_good)
            state_q <= MASS_DISCHARGE;
        MASS_DISCHARGE:
          if (sense.supplies_discharged)
            state_q <= MASS_OFF;
        MASS_EMERG:
          if (!sense.offset_power_good)
            state_q <= MASS_DISCHARGE;
        default:
          state_q <= MASS_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Supply enables
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive.logic_supply_en <= 1'b0;
      drive.mirror_offset_supply_en <= 1'b0;
      drive.mirror_bias_supply_en <= 1'b0;
      drive.mirror_release_supply_en <= 1'b0;
    end
    else
    begin
      drive.logic_supply_en <= state_q != MASS_OFF && state_q != MASS_WAIT_HOLD;
      drive.mirror_offset_supply_en <= state_q inside {MASS_OFFSET_UP, MASS_BIAS_DELAY,
        MASS_BIAS_CMD, MASS_RUN, MASS_PARK} || (state_q == MASS_EMERG && !drive.mirror_output_disable_n);
      // Bias and release raised together; their order does not matter
      drive.mirror_bias_supply_en <= state_q inside {MASS_BIAS_CMD, MASS_RUN, MASS_PARK};
      drive.mirror_release_supply_en <= state_q inside {MASS_BIAS_CMD, MASS_RUN, MASS_PARK};
    end
  end

  // ---------------------------------------------------------------
  // Array control signals
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive.power_down_n <= 1'b0;
      drive.mirror_output_disable_n <= 1'b0;
      drive.logic_inputs_en <= 1'b0;
      drive.global_bias_cmd <= 1'b0;
      drive.park_req <= 1'b0;
    end
    else
    begin
      drive.power_down_n <= state_q inside {MASS_OFFSET_UP, MASS_BIAS_DELAY,
        MASS_BIAS_CMD, MASS_RUN, MASS_PARK};
      drive.logic_inputs_en <= sense.logic_supply_good && state_q inside {MASS_OFFSET_UP,
        MASS_BIAS_DELAY, MASS_BIAS_CMD, MASS_RUN, MASS_PARK};
      drive.global_bias_cmd <= state_q == MASS_BIAS_CMD;
      drive.park_req <= state_q == MASS_PARK;
      // High only in emergency, set one cycle after entering MASS_EMERG, to request an emergency park
      drive.mirror_output_disable_n <= state_q == MASS_EMERG;
    end
  end
endmodule

// ### test/mass_top_monitor.sv
`timescale 1ns/10ps
module mass_top_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire mass_pkg::mass_sense_type sense,
  input wire mass_pkg::mass_drive_type drive
);
  import mass_pkg::*;
  localparam int MIN_DLY = 10;
  int og_cnt;
  logic mir;
  assign mir = drive.mirror_offset_supply_en | drive.mirror_bias_supply_en
    | drive.mirror_release_supply_en;
  // Counts how long offset power-good has been up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      og_cnt <= 0;
    else
      og_cnt <= sense.offset_power_good ? og_cnt + 1 : 0;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_logic_first;
    mir |-> drive.logic_supply_en;
  endproperty
  a_logic_first: assert property (p_logic_first) else $error("mirror supply without logic");
  property p_bias_after;
    $rose(drive.mirror_bias_supply_en) |-> drive.mirror_offset_supply_en;
  endproperty
  a_bias_after: assert property (p_bias_after) else $error("bias before offset");
  property p_delay;
    $rose(drive.mirror_bias_supply_en) |-> og_cnt >= MIN_DLY;
  endproperty
  a_delay: assert property (p_delay) else $error("offset to bias delay short");
  property p_inputs_low;
    $rose(drive.logic_inputs_en) |-> sense.logic_supply_good;
  endproperty
  a_inputs_low: assert property (p_inputs_low) else $error("inputs before logic good");
  property p_keep_logic;
    $fell(drive.logic_supply_en) |-> !mir && sense.supplies_discharged;
  endproperty
  a_keep_logic: assert property (p_keep_logic) else $error("logic off too early");
  property p_pdn_inputs;
    $fell(drive.power_down_n) |-> ##[0:3] !drive.logic_inputs_en;
  endproperty
  a_pdn_inputs: assert property (p_pdn_inputs) else $error("inputs high in power down");
  property p_pg_order;
    $fell(sense.offset_power_good) && !sense.power_lost |-> !drive.mirror_offset_supply_en;
  endproperty
  a_pg_order: assert property (p_pg_order) else $error("offset enable still on");
  property p_hold_first;
    $rose(drive.logic_supply_en) |-> sense.output_enable_hold_n;
  endproperty
  a_hold_first: assert property (p_hold_first) else $error("enable before hold release");
  property p_gbias;
    $rose(drive.mirror_bias_supply_en) |-> ##[0:2] drive.global_bias_cmd;
  endproperty
  a_gbias: assert property (p_gbias) else $error("no global bias command");
  property p_park_off;
    $fell(drive.mirror_offset_supply_en) && !sense.power_lost |-> ##[0:1] !drive.power_down_n;
  endproperty
  a_park_off: assert property (p_park_off) else $error("power down strobe missing");
  property p_emerg;
    $rose(sense.power_lost) && drive.mirror_bias_supply_en
      |-> ##[1:4] !drive.mirror_bias_supply_en;
  endproperty
  a_emerg: assert property (p_emerg) else $error("bias kept on power loss");
  property p_dis_first;
    $fell(sense.offset_power_good) && sense.power_lost |-> drive.mirror_output_disable_n;
  endproperty
  a_dis_first: assert property (p_dis_first) else $error("disable late in park");
  property p_apb;
    pready |-> psel && penable;
  endproperty
  a_apb: assert property (p_apb) else $error("ready outside access");
  property p_loss_park;
    sense.power_lost && drive.mirror_bias_supply_en |-> ##[1:2] drive.mirror_output_disable_n;
  endproperty
  a_loss_park: assert property (p_loss_park) else $error("no park on power loss");
  c_run: cover property ($rose(drive.global_bias_cmd));
  c_park: cover property ($fell(drive.logic_supply_en));
  c_emerg: cover property ($rose(drive.mirror_output_disable_n));
endmodule
bind mass_top mass_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready, .sense, .drive);

// ### test/mass_supply_model.sv
`timescale 1ns/10ps
module mass_supply_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mass_pkg::mass_drive_type drive,
  input wire logic power_lost,
  output logic logic_supply_good,
  output logic offset_power_good,
  output logic supplies_discharged
);
  import mass_pkg::*;
  logic [2:0] lg_q;
  logic [2:0] og_q;
  logic [3:0] dc_q;
  // Supplies settle and drain a few cycles after their enables move
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lg_q <= 3'h0;
      og_q <= 3'h0;
      dc_q <= 4'hf;
    end
    else
    begin
      lg_q <= {lg_q[1:0], drive.logic_supply_en};
      og_q <= {og_q[1:0], drive.mirror_offset_supply_en & ~power_lost};
      dc_q <= {dc_q[2:0], ~(drive.mirror_offset_supply_en | drive.mirror_bias_supply_en
        | drive.mirror_release_supply_en)};
    end
  end
  assign logic_supply_good = lg_q[2];
  assign offset_power_good = og_q[2];
  assign supplies_discharged = &dc_q;
endmodule

// ### test/mass_top_tb.sv
`timescale 1ns/10ps
module mass_top_tb;
  import mass_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hold_n = 1'b0;
  logic lost = 1'b0;
  logic lg;
  logic og;
  logic dc;
  mass_sense_type sense;
  mass_drive_type drive;
  int mismatches = 0;
  int checked = 0;
  int n;
  logic [31:0] rd;
  logic err;
  assign sense = {lg, og, dc, hold_n, lost};
  mass_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sense, .drive);
  mass_supply_model supply (.pclk, .presetn, .drive, .power_lost(lost),
    .logic_supply_good(lg), .offset_power_good(og), .supplies_discharged(dc));
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wt(input int b, input logic v);
    int k;
    k = 0;
    while (drive[b] !== v && k < 400)
    begin
      @(posedge pclk);
      k++;
    end
    chk("drive_bit", 32'(v), 32'(drive[b]));
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("drive", 32'h0, 32'(drive));
    xfer(1'b0, 8'h08, 32'h0);
    chk("delay", OFFSET_TO_BIAS_CYCLES, rd);
    xfer(1'b1, 8'h08, 32'ha);
    xfer(1'b0, 8'h08, 32'h0);
    chk("delay", 32'ha, rd);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    $display("test registers done");
    xfer(1'b1, 8'h00, 32'h1);
    repeat (20) @(posedge pclk);
    chk("early_en", 32'h0, 32'(drive.logic_supply_en));
    hold_n <= 1'b1;
    wt(7, 1'b1);
    n = 0;
    while (drive.mirror_bias_supply_en !== 1'b1)
    begin
      @(posedge pclk);
      n += int'(og === 1'b1);
    end
    chk("bias_wait", 32'h1, 32'(n >= 10));
    wt(1, 1'b1);
    xfer(1'b1, 8'h00, 32'h5);
    xfer(1'b0, 8'h04, 32'h0);
    chk("status", 32'h16, rd);
    $display("test power up done");
    xfer(1'b1, 8'h00, 32'h0);
    wt(0, 1'b1);
    xfer(1'b1, 8'h00, 32'h2);
    wt(7, 1'b0);
    chk("pdn", 32'h0, 32'(drive.power_down_n));
    chk("logic_on", 32'h1, 32'(drive.logic_supply_en));
    wt(8, 1'b0);
    chk("inputs", 32'h0, 32'(drive.logic_inputs_en));
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b0, 8'h04, 32'h0);
    chk("status", 32'h0, rd);
    $display("test shutdown done");
    xfer(1'b1, 8'h00, 32'h1);
    wt(6, 1'b1);
    xfer(1'b1, 8'h00, 32'h5);
    lost <= 1'b1;
    wt(3, 1'b1);
    chk("pgood", 32'h1, 32'(og));
    wt(6, 1'b0);
    xfer(1'b0, 8'h04, 32'h0);
    chk("emerg", 32'h1, 32'(rd[5]));
    $display("test emergency done");
    conclude();
  end
endmodule
